// file: src/exc_pkg.sv
// Shared constants for the exception dispatch block.
package exc_pkg;
   // ----------------------------------------
   // Event codes
   // ----------------------------------------
   localparam logic [11:0] EVT_POR      = 12'h000;
   localparam logic [11:0] EVT_MANUAL   = 12'h020;
   localparam logic [11:0] EVT_MISS_RD  = 12'h040;
   localparam logic [11:0] EVT_MISS_WR  = 12'h060;
   localparam logic [11:0] EVT_FIRST_WR = 12'h080;
   localparam logic [11:0] EVT_PROT_RD  = 12'h0a0;
   localparam logic [11:0] EVT_PROT_WR  = 12'h0c0;
   localparam logic [11:0] EVT_ADDR_RD  = 12'h0e0;
   localparam logic [11:0] EVT_ADDR_WR  = 12'h100;
   localparam logic [11:0] EVT_TRAP     = 12'h160;
   localparam logic [11:0] EVT_ILL_GEN  = 12'h180;
   localparam logic [11:0] EVT_ILL_SLOT = 12'h1a0;
   localparam logic [11:0] EVT_BREAK    = 12'h1e0;
   localparam logic [11:0] EVT_DMA_ADDR = 12'h5c0;
   // ----------------------------------------
   // Vectors and state word layout
   // ----------------------------------------
   localparam logic [31:0] RESET_PC     = 32'ha000_0000;
   localparam logic [31:0] VEC_MISS     = 32'h0000_0400;
   localparam logic [31:0] VEC_GENERAL  = 32'h0000_0100;
   localparam logic [31:0] USER_LIMIT   = 32'h8000_0000;
   localparam logic [31:0] VBR_RESET    = 32'h0000_0000;
   localparam logic [31:0] SR_RESET     = 32'h7000_00f0;
   localparam int          SR_MD        = 30;
   localparam int          SR_RB        = 29;
   localparam int          SR_BL        = 28;
   localparam int          SR_IMASK_LSB = 4;
   localparam logic [3:0]  IMASK_RESET  = 4'hf;
   localparam int          RC_LSB       = 6;
   localparam int          VPN_LSB      = 10;
   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] OFF_EVT  = 8'h00;
   localparam logic [7:0] OFF_TRA  = 8'h04;
   localparam logic [7:0] OFF_VBR  = 8'h08;
   localparam logic [7:0] OFF_SR   = 8'h0c;
   localparam logic [7:0] OFF_SPC  = 8'h10;
   localparam logic [7:0] OFF_SSR  = 8'h14;
   localparam logic [7:0] OFF_TEA  = 8'h18;
   localparam logic [7:0] OFF_PAGE_ENTRY_HIGH = 8'h1c;
   localparam logic [7:0] OFF_TCTL = 8'h20;
   // ----------------------------------------
   // Instruction classes and access sizes
   // ----------------------------------------
   localparam logic [2:0] CLS_OTHER = 3'h0;
   localparam logic [2:0] CLS_LDC   = 3'h1;
   localparam logic [2:0] CLS_STC   = 3'h2;
   localparam logic [2:0] CLS_RTE   = 3'h3;
   localparam logic [2:0] CLS_LOAD_TRANSLATION_ENTRY_INSTR = 3'h4;
   localparam logic [2:0] CLS_SLEEP = 3'h5;
   localparam logic [2:0] CLS_TRAP  = 3'h6;
   localparam logic [1:0] SZ_BYTE   = 2'h0;
   localparam logic [1:0] SZ_WORD   = 2'h1;
   localparam logic [1:0] SZ_LONG   = 2'h2;
endpackage

// file: src/exception_dispatch.sv
// Reset and exception dispatch unit with a classic Wishbone register slave.
`timescale 1ns/1ns
// Summary of operation
// - Power-on or debug reset command: code 0x000, init base and state, jump 0xA0000000.
// - Manual reset pin low: code 0x020, init base and state, jump to reset address.
// - Any reset: base zero, privilege, bank and block flags one, mask all ones.
// - Pin resets drive reset indicator low and both state outputs high.
// - Translation faults store fault address, page number bits 31-10, keep space id.
// - Miss: all ways valid increments replace counter, else lowest invalid way.
// - Miss: code 0x040 read or 0x060 write, jump base plus 0x400.
// - Invalid entry: load hit way, code 0x040 or 0x060, jump base plus 0x100.
// - Store to clean page: load hit way, code 0x080, jump base plus 0x100.
// - Enforce the two-bit protection code for privileged and user modes.
// - Protection fault: load hit way, code 0x0A0 or 0x0C0, base plus 0x100.
// - Address error: odd fetch, misaligned word or long, user access at top half.
// - Address error: store fault address, code 0x0E0 or 0x100, base plus 0x100.
// - Trap: return to next instruction, store four times immediate, code 0x160.
// - Undefined or user privileged opcode outside slot: code 0x180, base plus 0x100.
// - Control load/store, return, entry load and sleep are privileged, except global base.
// - Illegal slot instruction: return to delayed branch, code 0x1A0.
// - Break trap: code 0x1E0, next address after, own address before execution.
// - Misaligned DMA access: return to next instruction, code 0x5C0, base plus 0x100.
// - General exception saves counter and state word, sets block, privilege, bank.
// - Exception with block flag set resets core registers and jumps to reset address.
module exception_dispatch
   import exc_pkg::*;
#(
   parameter int ADR_W = 8
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             power_on_reset_in_n_i,
   input  wire logic             manual_reset_in_n_i,
   input  wire logic             debug_port_reset_i,
   input  wire logic             acc_valid_i,
   input  wire logic [31:0]      acc_addr_i,
   input  wire logic             acc_write_i,
   input  wire logic [1:0]       acc_size_i,
   input  wire logic             acc_fetch_i,
   input  wire logic             acc_xlat_i,
   input  wire logic             tlb_hit_i,
   input  wire logic [1:0]       tlb_hit_way_i,
   input  wire logic             tlb_entry_valid_i,
   input  wire logic             tlb_dirty_i,
   input  wire logic [1:0]       page_protection_i,
   input  wire logic [3:0]       tlb_ways_valid_i,
   input  wire logic             instr_valid_i,
   input  wire logic [15:0]      instr_op_i,
   input  wire logic [2:0]       instr_class_i,
   input  wire logic             instr_gbr_i,
   input  wire logic             instr_pc_write_i,
   input  wire logic             instr_slot_i,
   input  wire logic [31:0]      instr_pc_i,
   input  wire logic [31:0]      instr_next_pc_i,
   input  wire logic [31:0]      slot_branch_pc_i,
   input  wire logic             break_i,
   input  wire logic             break_post_i,
   input  wire logic             dma_valid_i,
   input  wire logic [31:0]      dma_addr_i,
   input  wire logic [1:0]       dma_size_i,
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   output logic                  redirect_o,
   output logic      [31:0]      redirect_pc_o,
   output logic                  cpu_reset_o,
   output logic      [31:0]      cpu_state_word_o,
   output logic                  reset_indicator_out_n_o,
   output logic                  state_out_0_o,
   output logic                  state_out_1_o
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [2:0]  por_sync;
      logic [2:0]  man_sync;
      logic        por_n;
      logic        man_n;
      logic        in_reset;
      logic [11:0] evt;
      logic [9:0]  trap_immediate_reg;
      logic [31:0] vector_base;
      logic [31:0] sr;
      logic [31:0] saved_return_address;
      logic [31:0] saved_state_word;
      logic [31:0] fault_address_reg;
      logic [31:0] page_entry_high;
      logic [1:0]  rc;
      logic        redirect;
      logic [31:0] target;
      logic        cpu_rst;
      logic        dbl;
      logic        ack;
      logic [31:0] rdat;
   } state_s;

   state_s q;
   state_s d;

   function automatic logic misaligned(input logic [1:0] size, input logic [1:0] lo);
      misaligned = (size == SZ_WORD && lo[0]) || (size == SZ_LONG && lo != 2'h0);
   endfunction

   function automatic logic prot_ok(input logic [1:0] pr, input logic user, input logic wr);
      unique case (pr)
         2'h0:    prot_ok = !user && !wr;
         2'h1:    prot_ok = !user;
         2'h2:    prot_ok = !wr;
         default: prot_ok = 1'b1;
      endcase
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      for (int b = 0; b < 4; b++) begin
         merge[8*b +: 8] = sel[b] ? nw[8*b +: 8] : old[8*b +: 8];
      end
   endfunction

   // ----------------------------------------
   // Event detection
   // ----------------------------------------
   logic user_mode;
   logic undef_op;
   logic priv_op;
   logic ill_slot;
   logic ill_gen;
   logic trap_op;
   logic addr_err;
   logic xlat;
   logic tlb_miss;
   logic tlb_inv;
   logic prot_err;
   logic first_wr;
   logic brk;
   logic dma_err;
   logic any_exc;

   assign user_mode = !q.sr[SR_MD];
   assign undef_op  = instr_op_i[15:12] == 4'hf;
   assign priv_op   = (instr_class_i inside {CLS_RTE, CLS_LOAD_TRANSLATION_ENTRY_INSTR, CLS_SLEEP}) ||
                      ((instr_class_i inside {CLS_LDC, CLS_STC}) && !instr_gbr_i);
   assign ill_slot  = instr_valid_i && instr_slot_i &&
                      (undef_op || instr_pc_write_i || (priv_op && user_mode));
   assign ill_gen   = instr_valid_i && !instr_slot_i && (undef_op || (priv_op && user_mode));
   assign trap_op   = instr_valid_i && !instr_slot_i && instr_class_i == CLS_TRAP;
   assign addr_err  = acc_valid_i && ((acc_fetch_i && acc_addr_i[0]) ||
                      misaligned(acc_size_i, acc_addr_i[1:0]) ||
                      (user_mode && acc_addr_i >= USER_LIMIT));
   assign xlat      = acc_valid_i && acc_xlat_i && !addr_err;
   assign tlb_miss  = xlat && !tlb_hit_i;
   assign tlb_inv   = xlat && tlb_hit_i && !tlb_entry_valid_i;
   assign prot_err  = xlat && tlb_hit_i && tlb_entry_valid_i &&
                      !prot_ok(page_protection_i, user_mode, acc_write_i);
   assign first_wr  = xlat && tlb_hit_i && tlb_entry_valid_i && !prot_err && acc_write_i && !tlb_dirty_i;
   // A break is never taken while exceptions are blocked.
   assign brk       = break_i && !q.sr[SR_BL];
   assign dma_err   = dma_valid_i && misaligned(dma_size_i, dma_addr_i[1:0]);
   assign any_exc   = ill_slot || ill_gen || trap_op || addr_err || tlb_miss || tlb_inv ||
                      prot_err || first_wr || brk || dma_err;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic [11:0] code;
      logic [31:0] off;
      logic [31:0] ret;
      logic [7:0]  a;
      code = EVT_POR;
      off  = VEC_GENERAL;
      ret  = instr_pc_i;
      a    = 8'(wb_adr_i);
      d          = q;
      d.redirect = 1'b0;
      d.cpu_rst  = 1'b0;
      d.dbl      = 1'b0;
      d.ack      = 1'b0;
      d.por_sync = {q.por_sync[1:0], power_on_reset_in_n_i};
      d.man_sync = {q.man_sync[1:0], manual_reset_in_n_i};
      if (q.por_sync[1] == q.por_sync[2]) begin
         d.por_n = q.por_sync[2];
      end
      if (q.man_sync[1] == q.man_sync[2]) begin
         d.man_n = q.man_sync[2];
      end

      if (wb_cyc_i && wb_stb_i && !q.ack) begin
         d.ack = 1'b1;
         unique case (a)
            OFF_EVT:  d.rdat = {20'h0, q.evt};
            OFF_TRA:  d.rdat = {22'h0, q.trap_immediate_reg};
            OFF_VBR:  d.rdat = q.vector_base;
            OFF_SR:   d.rdat = q.sr;
            OFF_SPC:  d.rdat = q.saved_return_address;
            OFF_SSR:  d.rdat = q.saved_state_word;
            OFF_TEA:  d.rdat = q.fault_address_reg;
            OFF_PAGE_ENTRY_HIGH: d.rdat = q.page_entry_high;
            OFF_TCTL: d.rdat = 32'(q.rc) << RC_LSB;
            default:  d.rdat = 32'h0;
         endcase
         if (wb_we_i) begin
            unique case (a)
               OFF_EVT:  d.evt  = 12'(merge({20'h0, q.evt}, wb_dat_i, wb_sel_i));
               OFF_TRA:  d.trap_immediate_reg  = {8'(merge({22'h0, q.trap_immediate_reg}, wb_dat_i, wb_sel_i) >> 2), 2'h0};
               OFF_VBR:  d.vector_base  = merge(q.vector_base, wb_dat_i, wb_sel_i);
               OFF_SR:   d.sr   = merge(q.sr, wb_dat_i, wb_sel_i);
               OFF_SPC:  d.saved_return_address  = merge(q.saved_return_address, wb_dat_i, wb_sel_i);
               OFF_SSR:  d.saved_state_word  = merge(q.saved_state_word, wb_dat_i, wb_sel_i);
               OFF_TEA:  d.fault_address_reg  = merge(q.fault_address_reg, wb_dat_i, wb_sel_i);
               OFF_PAGE_ENTRY_HIGH: d.page_entry_high = merge(q.page_entry_high, wb_dat_i, wb_sel_i);
               OFF_TCTL: d.rc   = 2'(merge(32'(q.rc) << RC_LSB, wb_dat_i, wb_sel_i) >> RC_LSB);
               default:  d.rdat = 32'h0;
            endcase
         end
      end

      // Hardware updates come after the bus write so an event in the same cycle wins.
      if (any_exc && !q.in_reset) begin
         if (q.sr[SR_BL]) begin
            d.sr       = SR_RESET;
            d.vector_base      = VBR_RESET;
            d.target   = RESET_PC;
            d.redirect = 1'b1;
            d.cpu_rst  = 1'b1;
            d.dbl      = 1'b1;
         end else begin
            if (ill_slot) begin
               code = EVT_ILL_SLOT;
               ret  = slot_branch_pc_i;
            end else if (ill_gen) begin
               code = EVT_ILL_GEN;
            end else if (trap_op) begin
               code  = EVT_TRAP;
               ret   = instr_next_pc_i;
               d.trap_immediate_reg = {instr_op_i[7:0], 2'h0};
            end else if (addr_err) begin
               code  = acc_write_i ? EVT_ADDR_WR : EVT_ADDR_RD;
               d.fault_address_reg = acc_addr_i;
            end else if (tlb_miss || tlb_inv || prot_err || first_wr) begin
               d.fault_address_reg = acc_addr_i;
               d.page_entry_high[31:VPN_LSB] = acc_addr_i[31:VPN_LSB];
               if (tlb_miss) begin
                  code = acc_write_i ? EVT_MISS_WR : EVT_MISS_RD;
                  off  = VEC_MISS;
                  if (&tlb_ways_valid_i) begin
                     d.rc = q.rc + 2'h1;
                  end else begin
                     for (int w = 3; w >= 0; w--) begin
                        if (!tlb_ways_valid_i[w]) begin
                           d.rc = 2'(w);
                        end
                     end
                  end
               end else begin
                  d.rc = tlb_hit_way_i;
                  if (tlb_inv) begin
                     code = acc_write_i ? EVT_MISS_WR : EVT_MISS_RD;
                  end else if (prot_err) begin
                     code = acc_write_i ? EVT_PROT_WR : EVT_PROT_RD;
                  end else begin
                     code = EVT_FIRST_WR;
                  end
               end
            end else if (brk) begin
               code = EVT_BREAK;
               ret  = break_post_i ? instr_next_pc_i : instr_pc_i;
            end else begin
               code = EVT_DMA_ADDR;
               ret  = instr_next_pc_i;
            end
            d.evt      = code;
            d.saved_return_address      = ret;
            d.saved_state_word      = q.sr;
            d.sr       = q.sr | (32'h1 << SR_BL) | (32'h1 << SR_MD) | (32'h1 << SR_RB);
            d.target   = q.vector_base + off;
            d.redirect = 1'b1;
         end
      end

      if (!q.por_n || !q.man_n) begin
         // Held in reset: pin resets keep code, base, state word, fault and page registers and counter initialised until release.
         d.in_reset = 1'b1;
         d.evt      = q.por_n ? EVT_MANUAL : EVT_POR;
         d.vector_base      = VBR_RESET;
         d.sr       = SR_RESET;
         d.fault_address_reg      = 32'h0;
         d.page_entry_high     = 32'h0;
         d.rc       = 2'h0;
         d.redirect = 1'b0;
         d.cpu_rst  = 1'b1;
         d.dbl      = 1'b0;
      end else if (q.in_reset) begin
         d.in_reset = 1'b0;
         d.redirect = 1'b1;
         d.target   = RESET_PC;
      end else if (debug_port_reset_i) begin
         d.evt      = EVT_POR;
         d.vector_base      = VBR_RESET;
         d.sr       = SR_RESET;
         d.target   = RESET_PC;
         d.redirect = 1'b1;
         d.cpu_rst  = 1'b1;
         d.dbl      = 1'b0;
      end
   end

   // The global reset behaves as a power-on reset held until release.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q          <= '0;
         q.por_sync <= 3'h7;
         q.man_sync <= 3'h7;
         q.por_n    <= 1'b1;
         q.man_n    <= 1'b1;
         q.in_reset <= 1'b1;
         q.sr       <= SR_RESET;
         q.cpu_rst  <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign wb_dat_o                = q.rdat;
   assign wb_ack_o                = q.ack;
   assign redirect_o              = q.redirect;
   assign redirect_pc_o           = q.target;
   assign cpu_reset_o             = q.cpu_rst;
   assign cpu_state_word_o        = q.sr;
   assign reset_indicator_out_n_o = !q.in_reset;
   assign state_out_0_o           = q.in_reset || q.dbl;
   assign state_out_1_o           = q.in_reset || q.dbl;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   logic gen_ok;
   assign gen_ok = any_exc && !q.in_reset && !q.sr[SR_BL] && q.por_n && q.man_n && !debug_port_reset_i;

   property p_debug_reset;
      !q.in_reset && q.por_n && q.man_n && debug_port_reset_i |=>
         q.evt == EVT_POR && redirect_o && redirect_pc_o == RESET_PC;
   endproperty
   a_debug_reset: assert property (p_debug_reset) else $error("debug reset dispatch wrong");

   property p_manual_code;
      !q.man_n && q.por_n |=> q.evt == EVT_MANUAL;
   endproperty
   a_manual_code: assert property (p_manual_code) else $error("manual reset code wrong");

   property p_reset_state;
      redirect_o && redirect_pc_o == RESET_PC && (cpu_reset_o || $past(q.in_reset)) |->
         q.vector_base == VBR_RESET && q.sr[SR_MD] && q.sr[SR_RB] && q.sr[SR_BL] &&
         q.sr[SR_IMASK_LSB +: 4] == IMASK_RESET;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("reset state word wrong");

   property p_reset_pins;
      !q.por_n |=> !reset_indicator_out_n_o && state_out_0_o && state_out_1_o;
   endproperty
   a_reset_pins: assert property (p_reset_pins) else $error("reset pins wrong");

   property p_fault_addr;
      gen_ok && !ill_slot && !ill_gen && !trap_op && (tlb_miss || tlb_inv || prot_err || first_wr) |=>
         q.fault_address_reg == $past(acc_addr_i) && q.page_entry_high[31:VPN_LSB] == $past(acc_addr_i[31:VPN_LSB]);
   endproperty
   a_fault_addr: assert property (p_fault_addr) else $error("fault address not stored");

   property p_miss_vector;
      gen_ok && !ill_slot && !ill_gen && !trap_op && tlb_miss |=>
         redirect_o && redirect_pc_o == $past(q.vector_base) + VEC_MISS;
   endproperty
   a_miss_vector: assert property (p_miss_vector) else $error("miss vector wrong");

   property p_rc_full;
      gen_ok && !ill_slot && !ill_gen && !trap_op && tlb_miss && &tlb_ways_valid_i |=>
         q.rc == $past(q.rc) + 2'h1;
   endproperty
   a_rc_full: assert property (p_rc_full) else $error("replace counter not advanced");

   property p_trap;
      gen_ok && !ill_slot && !ill_gen && trap_op |=>
         q.evt == EVT_TRAP && q.trap_immediate_reg == {$past(instr_op_i[7:0]), 2'h0} && q.saved_return_address == $past(instr_next_pc_i);
   endproperty
   a_trap: assert property (p_trap) else $error("trap dispatch wrong");

   property p_addr_err;
      gen_ok && !ill_slot && !ill_gen && !trap_op && addr_err |=>
         q.fault_address_reg == $past(acc_addr_i) && redirect_pc_o == $past(q.vector_base) + VEC_GENERAL;
   endproperty
   a_addr_err: assert property (p_addr_err) else $error("address error dispatch wrong");

   property p_save_state;
      gen_ok |=> q.saved_state_word == $past(q.sr) && q.sr[SR_BL] && q.sr[SR_MD] && q.sr[SR_RB];
   endproperty
   a_save_state: assert property (p_save_state) else $error("state not saved");

   property p_blocked;
      any_exc && q.sr[SR_BL] && !q.in_reset && q.por_n && q.man_n |=>
         cpu_reset_o && redirect_pc_o == RESET_PC;
   endproperty
   a_blocked: assert property (p_blocked) else $error("blocked exception not reset");

   c_miss:   cover property (gen_ok && tlb_miss);
   c_trap:   cover property (gen_ok && trap_op);
   c_dbl:    cover property (q.dbl);
   c_manual: cover property (!q.man_n ##1 q.man_n);

endmodule // exception_dispatch

// file: verif/mmu_model.sv
// Translation unit stand-in that answers each lookup in the way the bench selects.
`timescale 1ns/1ns
module mmu_model (
   input  wire logic [1:0]  mode_i,
   input  wire logic [31:0] addr_i,
   output logic             tlb_hit_o,
   output logic [1:0]       tlb_hit_way_o,
   output logic             tlb_entry_valid_o,
   output logic             tlb_dirty_o,
   output logic [1:0]       page_protection_o,
   output logic [3:0]       tlb_ways_valid_o
);
   // Modes: 0 miss, 1 invalid entry, 2 clean page, 3 read-only page; the way follows the address.
   assign tlb_hit_o         = (mode_i != 2'h0);
   assign tlb_hit_way_o     = addr_i[11:10];
   assign tlb_entry_valid_o = (mode_i != 2'h1);
   assign tlb_dirty_o       = (mode_i == 2'h3);
   assign page_protection_o = (mode_i == 2'h3) ? 2'h0 : 2'h3;
   assign tlb_ways_valid_o  = 4'hf;
endmodule // mmu_model

// file: verif/cpu_reset_and_exception_dispatch_test.sv
// Self-checking bench for the exception dispatch unit.
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
   $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module cpu_reset_and_exception_dispatch_test;
   import exc_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, power_on_reset_in_n_i = 1'b0, manual_reset_in_n_i = 1'b1;
   logic debug_port_reset_i = 1'b0;
   logic acc_valid_i = 1'b0, acc_write_i = 1'b0, acc_fetch_i = 1'b0, acc_xlat_i = 1'b0, instr_valid_i = 1'b0;
   logic instr_gbr_i = 1'b0, instr_pc_write_i = 1'b0, instr_slot_i = 1'b0, break_i = 1'b0, break_post_i = 1'b0;
   logic dma_valid_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, redirect_o, cpu_reset_o;
   logic reset_indicator_out_n_o, state_out_0_o, state_out_1_o, tlb_hit_i, tlb_entry_valid_i, tlb_dirty_i;
   logic [1:0] acc_size_i = '0, dma_size_i = '0, mode = '0, tlb_hit_way_i, page_protection_i;
   logic [2:0] instr_class_i = '0;
   logic [3:0] wb_sel_i = 4'hf, tlb_ways_valid_i;
   logic [7:0] wb_adr_i = '0, imm;
   logic [15:0] instr_op_i = '0;
   logic [31:0] acc_addr_i = '0, instr_pc_i = '0, instr_next_pc_i = '0, slot_branch_pc_i = '0, dma_addr_i = '0;
   logic [31:0] wb_dat_i = '0, wb_dat_o, redirect_pc_o, cpu_state_word_o, q, t, v, a, n, pc;
   int seed = 26, bad_count = 0, n_tests = 0;

   exception_dispatch dut (.*);
   mmu_model mmu (.mode_i(mode), .addr_i(acc_addr_i), .tlb_hit_o(tlb_hit_i), .tlb_hit_way_o(tlb_hit_way_i),
      .tlb_entry_valid_o(tlb_entry_valid_i), .tlb_dirty_o(tlb_dirty_i), .page_protection_o(page_protection_i),
      .tlb_ways_valid_o(tlb_ways_valid_i));

   initial forever #25 clk_i = ~clk_i;
   // ----------------------------------------
   // Bus and event helpers
   // ----------------------------------------
   task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we; wb_adr_i <= ad; wb_dat_i <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      r = wb_dat_o;
      wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
   endtask
   task automatic arm(input logic [31:0] sr);
      v = $random(seed) & 32'hffff_f000;
      wb(1'b1, OFF_VBR, v, q);
      wb(1'b1, OFF_SR, sr, q);
   endtask
   // The request was set at the current edge; it is taken at the next one and answered one later.
   task automatic go(output logic [31:0] p);
      @(posedge clk_i);
      acc_valid_i <= 1'b0; instr_valid_i <= 1'b0; debug_port_reset_i <= 1'b0; break_i <= 1'b0; dma_valid_i <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i);
         if (redirect_o === 1'b1) break;
      end
      // The target register holds its last value, so a missing pulse must not let a stale target pass.
      p = (redirect_o === 1'b1) ? redirect_pc_o : 'x;
   endtask
   function automatic logic [11:0] evt_of(input int m);
      return (m == 3) ? EVT_PROT_WR : (m == 2) ? EVT_FIRST_WR : EVT_MISS_WR;
   endfunction
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // A full run needs a few hundred cycles, so this margin only trips on a hang.
   initial begin
      repeat (4000) @(posedge clk_i);
      bad_count++;
      stop_test();
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      power_on_reset_in_n_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      wb(1'b0, OFF_SR, '0, q); `CHK(q, 32'h7000_00f0)
      wb(1'b0, OFF_EVT, '0, q); `CHK(q[11:0], EVT_POR)
      for (int m = 0; m < 4; m++) begin
         arm(32'h4000_0000);
         wb(1'b0, OFF_TCTL, '0, t);
         a = $random(seed) & 32'h7fff_fffc;
         mode <= m[1:0]; acc_addr_i <= a; acc_write_i <= 1'b1; acc_size_i <= SZ_LONG; acc_xlat_i <= 1'b1;
         acc_valid_i <= 1'b1;
         go(pc); `CHK(pc, v + ((m == 0) ? VEC_MISS : VEC_GENERAL))
         wb(1'b0, OFF_EVT, '0, q); `CHK(q[11:0], evt_of(m))
         wb(1'b0, OFF_TEA, '0, q); `CHK(q, a)
         wb(1'b0, OFF_PAGE_ENTRY_HIGH, '0, q); `CHK(q[31:10], a[31:10])
         wb(1'b0, OFF_TCTL, '0, q); `CHK(q[7:6], (m == 0) ? t[7:6] + 2'h1 : a[11:10])
         wb(1'b0, OFF_SR, '0, q); `CHK(q, 32'h7000_0000)
         wb(1'b0, OFF_SSR, '0, q); `CHK(q, 32'h4000_0000)
      end
      arm(32'h0000_0000);
      a = 32'h8000_0000 | ($random(seed) & 32'h7fff_fffc);
      acc_addr_i <= a; acc_write_i <= 1'b0; acc_xlat_i <= 1'b0; acc_valid_i <= 1'b1;
      go(pc); `CHK(pc, v + VEC_GENERAL)
      wb(1'b0, OFF_EVT, '0, q); `CHK(q[11:0], EVT_ADDR_RD)
      wb(1'b0, OFF_TEA, '0, q); `CHK(q, a)
      arm(32'h4000_0000);
      imm = 8'($random(seed));
      n = $random(seed) & 32'hffff_fffe;
      instr_class_i <= CLS_TRAP; instr_op_i <= {8'hc3, imm}; instr_next_pc_i <= n; instr_valid_i <= 1'b1;
      go(pc); `CHK(pc, v + VEC_GENERAL)
      wb(1'b0, OFF_TRA, '0, q); `CHK(q, {22'h0, imm, 2'h0})
      wb(1'b0, OFF_SPC, '0, q); `CHK(q, n)
      wb(1'b0, OFF_EVT, '0, q); `CHK(q[11:0], EVT_TRAP)
      arm(32'h0000_0000);
      instr_class_i <= CLS_RTE; instr_valid_i <= 1'b1;
      go(pc); `CHK(pc, v + VEC_GENERAL)
      wb(1'b0, OFF_EVT, '0, q); `CHK(q[11:0], EVT_ILL_GEN)
      instr_class_i <= CLS_OTHER; instr_op_i <= 16'hf00d; instr_valid_i <= 1'b1;
      go(pc); `CHK(pc, RESET_PC)
      wb(1'b0, OFF_SR, '0, q); `CHK(q, 32'h7000_00f0)
      `CHK(cpu_state_word_o, 32'h7000_00f0)
      for (int k = 0; k < 2; k++) begin
         arm(32'h4000_0000);
         if (k == 0) manual_reset_in_n_i <= 1'b0;
         else power_on_reset_in_n_i <= 1'b0;
         repeat (6) @(posedge clk_i);
         `CHK({reset_indicator_out_n_o, state_out_1_o, state_out_0_o, cpu_reset_o}, 4'h7)
         manual_reset_in_n_i <= 1'b1; power_on_reset_in_n_i <= 1'b1;
         repeat (10) @(posedge clk_i);
         wb(1'b0, OFF_EVT, '0, q); `CHK(q[11:0], k ? EVT_POR : EVT_MANUAL)
         wb(1'b0, OFF_VBR, '0, q); `CHK(q, 32'h0)
      end
      debug_port_reset_i <= 1'b1;
      go(pc); `CHK(pc, RESET_PC)
      wb(1'b0, OFF_EVT, '0, q); `CHK(q[11:0], EVT_POR)
      arm(32'h4000_0000);
      n = $random(seed);
      instr_class_i <= CLS_OTHER; instr_op_i <= 16'h0009; instr_pc_write_i <= 1'b1; instr_slot_i <= 1'b1;
      slot_branch_pc_i <= n; instr_valid_i <= 1'b1;
      go(pc); `CHK(pc, v + VEC_GENERAL)
      wb(1'b0, OFF_SPC, '0, q); `CHK(q, n)
      wb(1'b0, OFF_EVT, '0, q); `CHK(q[11:0], EVT_ILL_SLOT)
      for (int k = 0; k < 2; k++) begin
         arm(32'h4000_0000);
         n = $random(seed);
         a = $random(seed);
         instr_next_pc_i <= n; instr_pc_i <= a; break_post_i <= k[0]; break_i <= 1'b1;
         go(pc); `CHK(pc, v + VEC_GENERAL)
         wb(1'b0, OFF_SPC, '0, q); `CHK(q, k ? n : a)
         wb(1'b0, OFF_EVT, '0, q); `CHK(q[11:0], EVT_BREAK)
      end
      arm(32'h4000_0000);
      n = $random(seed);
      dma_addr_i <= $random(seed) | 32'h1; dma_size_i <= SZ_WORD; instr_next_pc_i <= n; dma_valid_i <= 1'b1;
      go(pc); `CHK(pc, v + VEC_GENERAL)
      wb(1'b0, OFF_SPC, '0, q); `CHK(q, n)
      wb(1'b0, OFF_EVT, '0, q); `CHK(q[11:0], EVT_DMA_ADDR)
      stop_test();
   end
endmodule // cpu_reset_and_exception_dispatch_test
